// ### include/adcsr_pkg.sv
package adcsr_pkg;

  // serial frame
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned BITCNT_W     = 4;
  localparam logic [3:0]  LAST_BIT     = 4'hf;

  // frame kind in the two top bits of every received word
  localparam int unsigned KIND_HI      = 15;
  localparam int unsigned KIND_LO      = 14;
  localparam logic [1:0]  KIND_NONE    = 2'h0;
  localparam logic [1:0]  KIND_CALDATA = 2'h1;
  localparam logic [1:0]  KIND_CTRL    = 2'h2;

  // control word field positions
  localparam int unsigned CTL_PM_HI    = 9;
  localparam int unsigned CTL_PM_LO    = 8;
  localparam int unsigned CTL_RD_HI    = 7;
  localparam int unsigned CTL_RD_LO    = 6;
  localparam int unsigned CTL_MODE     = 5;
  localparam int unsigned CTL_CONV     = 4;
  localparam int unsigned CTL_KIND     = 3;
  localparam int unsigned CTL_SEL_HI   = 2;
  localparam int unsigned CTL_SEL_LO   = 1;
  localparam int unsigned CTL_START    = 0;

  // read source select codes
  localparam logic [1:0]  RD_CAL       = 2'h2;
  localparam logic [1:0]  RD_STATUS    = 2'h3;

  // calibration selection codes
  localparam logic [1:0]  SEL_ALL      = 2'h0;
  localparam logic [1:0]  SEL_GAIN_OFS = 2'h1;
  localparam logic [1:0]  SEL_OFS      = 2'h2;
  localparam logic [1:0]  SEL_GAIN     = 2'h3;

  // calibration register storage
  localparam int unsigned CAL_COUNT    = 10;
  localparam int unsigned CAL_DATA_W   = 14;
  localparam int unsigned CAL_IDX_W    = 4;
  localparam logic [3:0]  IDX_GAIN     = 4'h0;
  localparam logic [3:0]  IDX_OFFSET   = 4'h1;
  localparam logic [3:0]  IDX_DAC_LAST = 4'h9;

  // reset values
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [13:0] CAL_RESET    = 14'h0000;

  // core cycles the read word keeps refreshing after a frame or engine write
  localparam logic [1:0]  TX_REFRESH   = 2'h3;

endpackage : adcsr_pkg

// ### design/adcsr_cal_mem.sv
`timescale 1ns/1ns
`default_nettype none

module adcsr_cal_mem (
  input  wire logic                              clk,
  input  wire logic                              reset,
  input  wire logic                              wr_en,
  input  wire logic [adcsr_pkg::CAL_IDX_W-1:0]   wr_idx,
  input  wire logic [adcsr_pkg::CAL_DATA_W-1:0]  wr_data,
  input  wire logic [adcsr_pkg::CAL_IDX_W-1:0]   rd_idx,
  output logic      [adcsr_pkg::CAL_DATA_W-1:0]  rd_data
);
  import adcsr_pkg::*;

  typedef struct packed {
    logic [CAL_COUNT-1:0][CAL_DATA_W-1:0] cells;
    logic [CAL_DATA_W-1:0]                rdata;
  } adcsr_mem_t;

  adcsr_mem_t mem_reg;
  adcsr_mem_t mem_next;

  always_comb begin
    mem_next = mem_reg;
    if (wr_en && (wr_idx <= IDX_DAC_LAST)) begin
      mem_next.cells[wr_idx] = wr_data;
    end
    // out-of-range index reads zero rather than x
    if (rd_idx <= IDX_DAC_LAST) begin
      mem_next.rdata = mem_reg.cells[rd_idx];
    end else begin
      mem_next.rdata = CAL_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rd_data = mem_reg.rdata;

endmodule : adcsr_cal_mem

`default_nettype wire

// ### design/adcsr_regs.sv
// How it works
// R01 - status word is sixteen bits, read only; frames never write it
// R02 - read-select code 11 in a control write returns status on following reads
// R03 - status word is zero after reset
// R04 - status bits 15 and 13..10 always read zero
// R05 - bit 14 is one while conversion or calibration is busy
// R06 - bits 9:8 mirror the power management setting
// R07 - bits 7:6 read one whenever the status word is returned
// R08 - bit 5 shows interface mode; cleared after every frame without control write
// R09 - bit 4 reads zero
// R10 - bit 3 shows self (0) or system (1) calibration kind
// R11 - bit 0 reads one while calibration runs
// R12 - bits 2:1 show the calibration selection code
// R13 - ten calibration registers: gain, offset, eight DAC, host read and write
// R14 - calibration engine updates the registers without host writes
// R15 - selection 00 all ten, 01 gain+offset, 10 offset, 11 gain
// R16 - host does not read and write calibration registers in one frame
// R17 - host reads calibration registers with read-select 10
// R18 - pointer returns to sequence start on control write and after last access
// R19 - start is gain, except offset-only selection starts at offset
// R20 - pointer advances after each calibration access when set has several
// R21 - aborted sequence is reset by the next control write
// R22 - calibration read words carry two leading zeros
// R23 - in interface mode 1 the host completes all calibration reads
// R24 - full order: gain, offset, then DAC registers ascending
// R25 - start flag zero makes selection bits an address, not a calibration
// R26 - calibration register is sixteen bits: two zeros and fourteen data
`timescale 1ns/1ns
`default_nettype none

module adcsr_regs (
  input  wire logic                              CLK,
  input  wire logic                              RESET,
  // serial link, own clock
  input  wire logic                              SCLK,
  input  wire logic                              SYNC_N,
  input  wire logic                              DIN,
  output logic                                   DOUT,
  output logic                                   DOUT_EN,
  // state of the conversion engine (pins, asynchronous)
  input  wire logic                              CONV_BUSY,
  input  wire logic                              CAL_BUSY,
  // coefficient updates from the calibration engine (CLK domain)
  input  wire logic                              CAL_UPD_VALID,
  input  wire logic [adcsr_pkg::CAL_IDX_W-1:0]   CAL_UPD_IDX,
  input  wire logic [adcsr_pkg::CAL_DATA_W-1:0]  CAL_UPD_DATA,
  // control outputs
  output logic                                   CONV_START,
  output logic                                   CAL_START,
  output logic                                   CAL_KIND,
  output logic [1:0]                             CAL_SEL,
  output logic [1:0]                             POWER_MGMT,
  output logic                                   IFACE_MODE1,
  output logic [adcsr_pkg::CAL_IDX_W-1:0]        CAL_PTR
);
  import adcsr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [CAL_IDX_W-1:0] seq_first(input logic [1:0] sel);
    seq_first = (sel == SEL_OFS) ? IDX_OFFSET : IDX_GAIN; // R19
  endfunction : seq_first

  function automatic logic [CAL_IDX_W-1:0] seq_last(input logic [1:0] sel);
    case (sel)
      SEL_ALL:      seq_last = IDX_DAC_LAST; // R15
      SEL_GAIN_OFS: seq_last = IDX_OFFSET;   // R15
      SEL_OFS:      seq_last = IDX_OFFSET;   // R15
      default:      seq_last = IDX_GAIN;     // R15
    endcase
  endfunction : seq_last

  //////////////////////////////////////////////////////////////////////////////
  // link domain state

  typedef struct packed {
    logic                rst_meta;
    logic                rst_sync;
    logic [WORD_W-1:0]   rx_shift;
    logic [WORD_W-1:0]   rx_word;
    logic                rx_tgl;
    logic [WORD_W-1:0]   tx_shift;
    logic                dout;
  } adcsr_link_t;

  adcsr_link_t lnk_reg;
  adcsr_link_t lnk_next;

  // frame position; SYNC_N high clears it at once, since SCLK may stop
  typedef struct packed {
    logic [BITCNT_W-1:0] bit_cnt;
    logic                dout_en;
  } adcsr_win_t;

  adcsr_win_t win_reg;
  adcsr_win_t win_next;

  //////////////////////////////////////////////////////////////////////////////
  // core domain state

  typedef struct packed {
    logic                 tgl_meta;
    logic                 tgl_sync;
    logic                 tgl_seen;
    logic                 conv_meta;
    logic                 conv_sync;
    logic                 calb_meta;
    logic                 calb_sync;
    logic [1:0]           power_mgmt;
    logic [1:0]           read_sel;
    logic                 iface_mode1;
    logic                 cal_kind;
    logic [1:0]           cal_sel;
    logic [CAL_IDX_W-1:0] ptr;
    logic [WORD_W-1:0]    tx_word;
    logic                 conv_start;
    logic                 cal_start;
    logic [1:0]           refresh;
  } adcsr_core_t;

  adcsr_core_t core_reg;
  adcsr_core_t core_next;

  logic                  mem_we;
  logic [CAL_IDX_W-1:0]  mem_widx;
  logic [CAL_DATA_W-1:0] mem_wdata;
  logic [CAL_DATA_W-1:0] mem_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // link: 16-bit frames, msb first, sampled on SCLK rise while SYNC_N low

  always_comb begin
    lnk_next          = lnk_reg;
    win_next          = win_reg;
    lnk_next.rst_meta = RESET;
    lnk_next.rst_sync = lnk_reg.rst_meta;
    if (lnk_reg.rst_sync) begin
      win_next        = '0;
      lnk_next.dout   = 1'b0;
      lnk_next.rx_tgl = 1'b0;
    end else if (SYNC_N) begin
      // frame ended early: drop the partial word
      win_next = '0;
    end else begin
      lnk_next.rx_shift = {lnk_reg.rx_shift[WORD_W-2:0], DIN};
      win_next.bit_cnt  = win_reg.bit_cnt + 4'h1;
      if (win_reg.bit_cnt == '0) begin
        // tx_word only moves just after a frame or engine write, so capture is safe
        lnk_next.dout     = core_reg.tx_word[WORD_W-1];
        lnk_next.tx_shift = {core_reg.tx_word[WORD_W-2:0], 1'b0};
        win_next.dout_en  = 1'b1;
      end else begin
        lnk_next.dout     = lnk_reg.tx_shift[WORD_W-1];
        lnk_next.tx_shift = {lnk_reg.tx_shift[WORD_W-2:0], 1'b0};
      end
      if (win_reg.bit_cnt == LAST_BIT) begin
        // counter wraps; the last bit stays driven until SYNC_N rises
        lnk_next.rx_word = {lnk_reg.rx_shift[WORD_W-2:0], DIN};
        lnk_next.rx_tgl  = ~lnk_reg.rx_tgl;
      end
    end
  end

  always_ff @(posedge SCLK) begin
    lnk_reg <= lnk_next;
  end

  // a cut frame ends here with no SCLK edge needed
  always_ff @(posedge SCLK or posedge SYNC_N) begin
    if (SYNC_N) begin
      win_reg <= '0;
    end else begin
      win_reg <= win_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // core: frame decode, pointer, status

  logic              frame_evt;
  logic [WORD_W-1:0] frm;
  logic [1:0]        frm_kind;
  logic              is_ctrl;
  logic              is_calwr;
  logic              is_calrd;
  logic              advance;

  always_comb begin
    // rx_word holds for a whole frame after the toggle, long past the sync delay
    frame_evt = core_reg.tgl_sync ^ core_reg.tgl_seen;
    frm       = lnk_reg.rx_word;
    frm_kind  = frm[KIND_HI:KIND_LO];
    is_ctrl   = frame_evt && (frm_kind == KIND_CTRL);
    is_calwr  = frame_evt && (frm_kind == KIND_CALDATA); // R13
    // a non-control frame returning a calibration word counts as one read access
    is_calrd  = frame_evt && !is_ctrl && (core_reg.read_sel == RD_CAL); // R17
    advance   = is_calwr || is_calrd; // R16
  end

  always_comb begin
    core_next            = core_reg;
    core_next.tgl_meta   = lnk_reg.rx_tgl;
    core_next.tgl_sync   = core_reg.tgl_meta;
    core_next.tgl_seen   = core_reg.tgl_sync;
    core_next.conv_meta  = CONV_BUSY;
    core_next.conv_sync  = core_reg.conv_meta;
    core_next.calb_meta  = CAL_BUSY;
    core_next.calb_sync  = core_reg.calb_meta;
    core_next.conv_start = 1'b0;
    core_next.cal_start  = 1'b0;

    mem_we    = 1'b0;
    mem_widx  = core_reg.ptr;
    mem_wdata = frm[CAL_DATA_W-1:0];

    if (is_ctrl) begin
      core_next.power_mgmt  = frm[CTL_PM_HI:CTL_PM_LO];
      core_next.read_sel    = frm[CTL_RD_HI:CTL_RD_LO]; // R02
      core_next.iface_mode1 = frm[CTL_MODE];
      core_next.cal_kind    = frm[CTL_KIND];
      core_next.cal_sel     = frm[CTL_SEL_HI:CTL_SEL_LO];
      core_next.ptr         = seq_first(frm[CTL_SEL_HI:CTL_SEL_LO]); // R18 R21
      core_next.conv_start  = frm[CTL_CONV];
      // start flag low leaves the code as a register address only
      core_next.cal_start   = frm[CTL_START]; // R25
    end else if (frame_evt) begin
      core_next.iface_mode1 = 1'b0; // R08
      if (advance) begin
        if (core_reg.ptr == seq_last(core_reg.cal_sel)) begin
          core_next.ptr = seq_first(core_reg.cal_sel); // R18
        end else begin
          // index order gain, offset, dac0..dac7
          core_next.ptr = core_reg.ptr + 4'h1; // R20 R24
        end
      end
    end

    if (CAL_UPD_VALID) begin
      // engine wins; the host is told to keep off during calibration
      mem_we    = 1'b1; // R14
      mem_widx  = CAL_UPD_IDX;
      mem_wdata = CAL_UPD_DATA;
    end else if (is_calwr) begin
      mem_we    = 1'b1; // R13
    end

    case (core_reg.read_sel)
      RD_STATUS: begin
        core_next.tx_word = {
          1'b0,                                      // R04
          core_reg.conv_sync | core_reg.calb_sync,   // R05
          4'h0,                                      // R04
          core_reg.power_mgmt,                       // R06
          2'h3,                                      // R07
          core_reg.iface_mode1,                      // R08
          1'b0,                                      // R09
          core_reg.cal_kind,                         // R10
          core_reg.cal_sel,                          // R12
          core_reg.calb_sync                         // R11
        }; // R01
      end
      RD_CAL: begin
        core_next.tx_word = {2'h0, mem_rdata}; // R22 R26
      end
      default: begin
        // conversion result path lives outside this block
        core_next.tx_word = STATUS_RESET;
      end
    endcase

    // word moves only just after a frame or engine write, never while the
    // link captures it; busy is therefore seen one frame late
    if (core_reg.refresh != 2'h0) begin
      core_next.refresh = core_reg.refresh - 2'h1;
    end else begin
      core_next.tx_word = core_reg.tx_word;
    end
    if (frame_evt || CAL_UPD_VALID) begin
      core_next.refresh = TX_REFRESH;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      core_reg         <= '0;
      core_reg.tx_word <= STATUS_RESET; // R03
      core_reg.ptr     <= IDX_GAIN;
    end else begin
      core_reg <= core_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // coefficient storage

  adcsr_cal_mem u_cal_mem (
    .clk     (CLK),
    .reset   (RESET),
    .wr_en   (mem_we),
    .wr_idx  (mem_widx),
    .wr_data (mem_wdata),
    .rd_idx  (core_reg.ptr),
    .rd_data (mem_rdata)
  );

  assign DOUT        = lnk_reg.dout;
  assign DOUT_EN     = win_reg.dout_en;
  assign CONV_START  = core_reg.conv_start;
  assign CAL_START   = core_reg.cal_start;
  assign CAL_KIND    = core_reg.cal_kind;
  assign CAL_SEL     = core_reg.cal_sel;
  assign POWER_MGMT  = core_reg.power_mgmt;
  assign IFACE_MODE1 = core_reg.iface_mode1;
  assign CAL_PTR     = core_reg.ptr;

endmodule : adcsr_regs

`default_nettype wire

// ### bench/adcsr_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none

module adcsr_regs_checker
  import adcsr_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RESET,
  input wire logic       SCLK,
  input wire logic       SYNC_N,
  input wire logic       DOUT_EN,
  input wire logic       CAL_START,
  input wire logic       CAL_KIND,
  input wire logic [1:0] CAL_SEL,
  input wire logic [1:0] POWER_MGMT,
  input wire logic       IFACE_MODE1,
  input wire logic [3:0] CAL_PTR
);
  // link logic leaves reset through two flops, so give it a few edges
  logic [2:0] link_age;
  always_ff @(posedge SCLK) begin
    if (RESET) link_age <= 3'h0;
    else if (link_age != 3'h7) link_age <= link_age + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  reset_clear_a: assert property (@(posedge CLK) RESET |=>
    (CAL_PTR == 4'h0 && CAL_SEL == 2'h0 && POWER_MGMT == 2'h0 && !CAL_KIND
     && !IFACE_MODE1 && !CAL_START)) else $error("outputs not cleared by reset");
  start_pulse_a: assert property (@(posedge CLK) disable iff (RESET)
    CAL_START |=> !CAL_START) else $error("calibration start held too long");
  ptr_range_a: assert property (@(posedge CLK) disable iff (RESET) CAL_PTR <= IDX_DAC_LAST)
    else $error("pointer beyond last register");
  ptr_gain_a: assert property (@(posedge CLK) disable iff (RESET)
    (CAL_SEL == SEL_GAIN) |-> (CAL_PTR == IDX_GAIN)) else $error("gain set off gain");
  ptr_ofs_a: assert property (@(posedge CLK) disable iff (RESET)
    (CAL_SEL == SEL_OFS) |-> (CAL_PTR == IDX_OFFSET)) else $error("offset set off offset");
  ptr_pair_a: assert property (@(posedge CLK) disable iff (RESET)
    (CAL_SEL == SEL_GAIN_OFS) |-> (CAL_PTR <= IDX_OFFSET)) else $error("pair set escaped");
  ptr_step_a: assert property (@(posedge CLK) disable iff (RESET)
    ($changed(CAL_PTR) && $stable(CAL_SEL) && CAL_SEL == SEL_ALL && CAL_PTR != IDX_GAIN)
    |-> (CAL_PTR == $past(CAL_PTR) + 4'h1)) else $error("pointer did not step by one");
  ptr_wrap_a: assert property (@(posedge CLK) disable iff (RESET)
    ($past(CAL_PTR) == IDX_DAC_LAST && $changed(CAL_PTR) && $stable(CAL_SEL))
    |-> (CAL_PTR == IDX_GAIN)) else $error("pointer did not wrap to gain");
  idle_quiet_a: assert property (@(posedge SCLK) disable iff (RESET || link_age < 3'h4)
    SYNC_N |-> !DOUT_EN) else $error("output driven outside frame");
  frame_drive_a: assert property (@(posedge SCLK) disable iff (RESET)
    $fell(SYNC_N) |=> DOUT_EN [*8]) else $error("output not driven in frame");
  cover property (@(posedge CLK) CAL_START);
  cover property (@(posedge CLK) CAL_PTR == IDX_DAC_LAST);
  cover property (@(posedge SCLK) $fell(SYNC_N));
endmodule : adcsr_regs_checker

bind adcsr_regs adcsr_regs_checker adcsr_regs_checker_i (
  .CLK(CLK), .RESET(RESET), .SCLK(SCLK), .SYNC_N(SYNC_N), .DOUT_EN(DOUT_EN),
  .CAL_START(CAL_START), .CAL_KIND(CAL_KIND), .CAL_SEL(CAL_SEL),
  .POWER_MGMT(POWER_MGMT), .IFACE_MODE1(IFACE_MODE1), .CAL_PTR(CAL_PTR)
);

`default_nettype wire

// ### bench/adcsr_host.sv
`timescale 1ns/1ns
`default_nettype none

module adcsr_host (
  output logic     sclk,
  output logic     sync_n,
  output logic     din,
  input wire logic dout,
  input wire logic dout_en
);
  initial begin
    sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end
  // bare clock pulses, for reset and cut frames; otherwise the clock stands still
  task automatic idle(input int n);
    repeat (n) begin
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
    end
  endtask : idle
  // one word per frame, never a read and a write mixed in one frame
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    sync_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      din = w[i];
      #62 sclk = 1'b1;
      #63 sclk = 1'b0;
      // a released line reads as the inverse, so an undriven bit shows
      r[i] = dout_en ? dout : ~dout;
    end
    #62 sync_n = 1'b1;
    din = ~din;
    // gap well above the refresh spacing of the read word
    #1000;
  endtask : xfer
  // frame abandoned after n bits
  task automatic cut(input int n);
    sync_n = 1'b0;
    din = 1'b1;
    idle(n);
    #62 sync_n = 1'b1;
    #1000;
  endtask : cut
endmodule : adcsr_host

`default_nettype wire

// ### bench/adcsr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

module adcsr_regs_tb;
  import adcsr_pkg::*;
  typedef struct packed {
    logic [1:0] pm; logic mode; logic kind; logic [1:0] sel; logic cbusy; logic kbusy;
  } adcsr_row_t;
  localparam adcsr_row_t ROWS [4] = '{'{2'h1, 1'b1, 1'b0, SEL_ALL, 1'b1, 1'b0},
    '{2'h2, 1'b0, 1'b1, SEL_GAIN_OFS, 1'b0, 1'b1}, '{2'h3, 1'b1, 1'b1, SEL_OFS, 1'b1, 1'b1},
    '{2'h0, 1'b0, 1'b0, SEL_GAIN, 1'b0, 1'b0}};
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        sclk, sync_n, din, dout, dout_en;
  logic        conv_busy = 1'b0, cal_busy = 1'b0, cal_upd_valid = 1'b0;
  logic [3:0]  cal_upd_idx = 4'h0;
  logic [13:0] cal_upd_data = 14'h0000;
  logic        conv_start, cal_start, cal_kind, iface_mode1;
  logic [1:0]  cal_sel, power_mgmt;
  logic [3:0]  cal_ptr;
  logic [15:0] w;
  adcsr_row_t  r;
  int          err_total = 0, num_checks = 0, n_cal = 0, n_conv = 0, i;

  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (cal_start === 1'b1) n_cal++;
    if (conv_start === 1'b1) n_conv++;
  end
  adcsr_host adcsr_host_i (.sclk(sclk), .sync_n(sync_n), .din(din), .dout(dout),
    .dout_en(dout_en));
  adcsr_regs adcsr_regs_i (.CLK(clk), .RESET(reset), .SCLK(sclk), .SYNC_N(sync_n),
    .DIN(din), .DOUT(dout), .DOUT_EN(dout_en), .CONV_BUSY(conv_busy), .CAL_BUSY(cal_busy),
    .CAL_UPD_VALID(cal_upd_valid), .CAL_UPD_IDX(cal_upd_idx), .CAL_UPD_DATA(cal_upd_data),
    .CONV_START(conv_start), .CAL_START(cal_start), .CAL_KIND(cal_kind), .CAL_SEL(cal_sel),
    .POWER_MGMT(power_mgmt), .IFACE_MODE1(iface_mode1), .CAL_PTR(cal_ptr));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] ctl(input logic [1:0] pm, input logic [1:0] rd,
    input logic mode, input logic conv, input logic kind, input logic [1:0] sel,
    input logic start);
    ctl = {KIND_CTRL, 4'h0, pm, rd, mode, conv, kind, sel, start};
  endfunction : ctl
  function automatic logic [13:0] cal_val(input int k);
    cal_val = 14'h2000 + 14'(k * 'h123);
  endfunction : cal_val
  task automatic complete_run;
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : check_word
  task automatic check_out(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : check_out
  ////////////////////////////////////////////////////////////////////////////
  // about forty frames of some 3 us each
  initial begin
    #400000;
    err_total++;
    complete_run();
  end
  initial begin
    fork
      begin repeat (6) @(posedge clk); #2 reset = 1'b0; end
      adcsr_host_i.idle(8);
    join
    check_out("reset", 16'h0000, {4'h0, conv_start, cal_start, cal_kind, cal_sel, power_mgmt,
      iface_mode1, cal_ptr});
    for (i = 0; i < 4; i++) begin
      r = ROWS[i];
      @(posedge clk);
      #2 conv_busy = r.cbusy;
      cal_busy = r.kbusy;
      adcsr_host_i.xfer(ctl(r.pm, RD_STATUS, r.mode, 1'b0, r.kind, r.sel, 1'b0), w);
      check_out("ctl", {6'h0, r.pm, r.mode, r.kind, r.sel, (r.sel == SEL_OFS) ? IDX_OFFSET
        : IDX_GAIN}, {6'h0, power_mgmt, iface_mode1, cal_kind, cal_sel, cal_ptr});
      adcsr_host_i.xfer(16'h0000, w);
      check_word("status", {1'b0, r.cbusy | r.kbusy, 4'h0, r.pm, RD_STATUS, r.mode, 1'b0,
        r.kind, r.sel, r.kbusy}, w);
      check_out("mode", 16'h0000, {15'h0, iface_mode1});
    end
    adcsr_host_i.xfer(ctl(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, SEL_ALL, 1'b0), w);
    for (i = 0; i < 10; i++) begin
      adcsr_host_i.xfer({KIND_CALDATA, cal_val(i)}, w);
      check_out("ptr", 16'((i + 1) % 10), {12'h0, cal_ptr});
    end
    @(posedge clk);
    #2 cal_upd_valid = 1'b1;
    cal_upd_idx = IDX_DAC_LAST;
    cal_upd_data = 14'h1abc;
    @(posedge clk);
    #2 cal_upd_valid = 1'b0;
    adcsr_host_i.xfer(ctl(2'h0, RD_CAL, 1'b0, 1'b0, 1'b0, SEL_ALL, 1'b0), w);
    for (i = 0; i < 10; i++) begin
      adcsr_host_i.xfer(16'h0000, w);
      check_word("cal", {2'h0, (i == 9) ? 14'h1abc : cal_val(i)}, w);
    end
    adcsr_host_i.xfer(ctl(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, SEL_GAIN_OFS, 1'b0), w);
    adcsr_host_i.xfer({KIND_CALDATA, 14'h0155}, w);
    check_out("ptr", 16'h0001, {12'h0, cal_ptr});
    adcsr_host_i.xfer(ctl(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, SEL_GAIN_OFS, 1'b0), w);
    check_out("ptr", 16'h0000, {12'h0, cal_ptr});
    adcsr_host_i.xfer(ctl(2'h0, RD_CAL, 1'b0, 1'b0, 1'b0, SEL_OFS, 1'b0), w);
    adcsr_host_i.xfer(16'h0000, w);
    check_word("ofs", {2'h0, cal_val(1)}, w);
    check_out("ptr", 16'h0001, {12'h0, cal_ptr});
    adcsr_host_i.xfer(ctl(2'h0, RD_CAL, 1'b0, 1'b0, 1'b0, SEL_GAIN, 1'b0), w);
    adcsr_host_i.xfer(16'h0000, w);
    check_word("gain", {2'h0, 14'h0155}, w);
    adcsr_host_i.cut(5);
    adcsr_host_i.xfer(ctl(2'h3, 2'h0, 1'b0, 1'b1, 1'b1, SEL_ALL, 1'b1), w);
    check_out("cal_start", 16'h0001, 16'(n_cal));
    check_out("conv_start", 16'h0001, 16'(n_conv));
    check_out("kind_pm", 16'h0007, {13'h0, cal_kind, power_mgmt});
    @(posedge clk);
    #2 reset = 1'b1;
    adcsr_host_i.idle(4);
    check_out("reset2", 16'h0000, {4'h0, conv_start, cal_start, cal_kind, cal_sel,
      power_mgmt, iface_mode1, cal_ptr});
    @(posedge clk);
    #2 reset = 1'b0;
    complete_run();
  end
endmodule : adcsr_regs_tb

`default_nettype wire
